//--- verilog/dc_map.svh
// constants for the L1 data cache bank and miss logic
// assumes byte addresses from the core and line-granular lower memory
// Operation
// - at most eight distinct lines outstanding
// - same-line requests share one entry
// - hold request for a line not already held while table full
// - lines and fills are 64 bytes
// - merge writes within one line buffer
// - eight banks, each sixteen bytes wide
// - conflict only same bank, different index
// - loads serviced in program order
// - two loads without conflict, else one
// - prefetch waits behind matching pending store
// - write-intent prefetch fills as modified
// - cast out line needed by other cache
// - modified line written back before ifetch
`ifndef DC_MAP_SVH
`define DC_MAP_SVH
`define DC_ADDR_W      32
`define DC_LINE_BYTES  64
`define DC_LINE_LSB    6
`define DC_BANKS       8
`define DC_BANK_BYTES  16
`define DC_BANK_LSB    4
`define DC_BANK_MSB    6
`define DC_INDEX_LSB   6
`define DC_CHUNKS      4
`define DC_MISS_MAX    8
`define DC_MISS_ID_W   3
`endif

//--- verilog/dc_pkg.sv
// types shared by the cache bank and miss logic
// assumes dc_map.svh is on the include path
`include "dc_map.svh"
package dc_pkg;
  localparam int LINE_W = `DC_ADDR_W - `DC_LINE_LSB;
  typedef logic [LINE_W-1:0] line_t;
  typedef enum logic [1:0] {REQ_LOAD, REQ_PREFETCH, REQ_PREFETCHW, REQ_IFETCH} req_kind_t;
  typedef struct packed {
    req_kind_t kind;
    line_t     line;
    logic      other_hit;  // line also held by the other L1
    logic      other_mod;  // data cache holds it modified
  } miss_req_t;
  typedef struct packed {
    logic                     valid;
    logic [`DC_MISS_ID_W-1:0] id;
    logic [8*`DC_LINE_BYTES-1:0] data;
  } fill_in_t;
  typedef struct packed {
    logic  valid;
    line_t line;
    logic  modified;
    logic  to_icache;
  } fill_out_t;
  typedef struct packed {
    logic                       valid;
    line_t                      line;
    logic [1:0]                 chunk;
    logic [8*`DC_BANK_BYTES-1:0] data;
    logic [`DC_BANK_BYTES-1:0]   be;
  } wc_write_t;
  typedef struct packed {
    logic                        valid;
    line_t                       line;
    logic [8*`DC_LINE_BYTES-1:0] data;
    logic [`DC_LINE_BYTES-1:0]   mask;
  } wc_flush_t;
endpackage

//--- verilog/miss_entry.sv
// one entry of the outstanding line request table
// assumes alloc and clear never hit the same entry in one cycle
`timescale 1ns/100ps
`include "dc_map.svh"
module miss_entry (
  input  wire logic              sys_clk,  // core clock
  input  wire logic              rst,      // async reset, high
  input  wire logic              ce,       // clock enable
  input  wire logic              alloc,    // take a new line
  input  wire logic              clear,    // fill returned
  input  wire dc_pkg::line_t     line_in,  // line to hold
  input  wire dc_pkg::req_kind_t kind_in,  // request kind to hold
  input  wire dc_pkg::line_t     cmp_line, // line to compare
  output logic                   valid,    // entry busy
  output dc_pkg::line_t          line,     // held line
  output dc_pkg::req_kind_t      kind,     // held kind
  output logic                   hit       // busy and same line
);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      valid <= 1'b0;
    end else if (ce) begin
      if (alloc) begin
        valid <= 1'b1;
      end else if (clear) begin
        valid <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      line <= '0;
      kind <= dc_pkg::REQ_LOAD;
    end else if (ce && alloc) begin
      line <= line_in;
      kind <= kind_in;
    end
  end

  assign hit = valid && (line == cmp_line);
endmodule

//--- verilog/l1_dcache_bank_and_miss_logic.sv
// banked L1 data array, dual load issue, miss table, write combiner
// assumes the core holds a miss request until ack and re-issues unserved loads
`timescale 1ns/100ps
`include "dc_map.svh"
module l1_dcache_bank_and_miss_logic #(
  parameter int IDX_W = 4  // index bits per bank
) (
  input  wire logic                          sys_clk,      // core clock
  input  wire logic                          rst,          // async reset, high
  input  wire logic                          ce,           // clock enable
  input  wire logic [1:0]                    ld_valid,     // [0] older load
  input  wire logic [`DC_ADDR_W-1:0]         ld0_addr,     // older load address
  input  wire logic [`DC_ADDR_W-1:0]         ld1_addr,     // younger load address
  output logic [1:0]                         ld_done_reg,  // loads served, pulse
  output logic [8*`DC_BANK_BYTES-1:0]        ld0_data_reg, // older load bank data
  output logic [8*`DC_BANK_BYTES-1:0]        ld1_data_reg, // younger load bank data
  input  wire logic                          st_valid,     // store commit to array
  input  wire logic [`DC_ADDR_W-1:0]         st_addr,      // store address
  input  wire logic [8*`DC_BANK_BYTES-1:0]   st_data,      // store bank data
  input  wire logic                          stq_valid,    // a store is pending
  input  wire dc_pkg::line_t                 stq_line,     // its line
  input  wire logic                          miss_valid,   // miss request held
  input  wire dc_pkg::miss_req_t             miss_req,     // miss request
  output logic                               miss_ack_reg, // request taken, pulse
  output logic [`DC_MISS_ID_W-1:0]           miss_id_reg,  // entry used
  output logic                               mreq_valid_reg, // line read out, pulse
  output dc_pkg::line_t                      mreq_line_reg,  // line to read
  output logic [`DC_MISS_ID_W-1:0]           mreq_id_reg,    // tag of read
  input  wire dc_pkg::fill_in_t              fill_in,        // returning line
  output dc_pkg::fill_out_t                  fill_out_reg,   // fill state, pulse
  output logic                               wb_req_reg,     // castout, level
  output dc_pkg::line_t                      wb_line_reg,    // castout line
  input  wire logic                          wb_done,        // castout written
  output logic                               ic_inval_reg,   // icache castout pulse
  output dc_pkg::line_t                      ic_inval_line_reg, // its line
  input  wire dc_pkg::wc_write_t             wc_wr,          // combining write
  input  wire logic                          fence,          // ordering fence
  output dc_pkg::wc_flush_t                  wc_flush_reg    // buffer out, pulse
);
  localparam int SETS = 1 << IDX_W;
  typedef enum {ST_IDLE, ST_CASTOUT} miss_state_t;

  logic [8*`DC_BANK_BYTES-1:0] bank_mem [`DC_BANKS][SETS];
  logic [2:0]       b0, b1, sb;
  logic [IDX_W-1:0] i0, i1, si;
  logic             conflict;
  assign b0 = ld0_addr[`DC_BANK_MSB:`DC_BANK_LSB];
  assign b1 = ld1_addr[`DC_BANK_MSB:`DC_BANK_LSB];
  assign sb = st_addr[`DC_BANK_MSB:`DC_BANK_LSB];
  assign i0 = ld0_addr[`DC_INDEX_LSB +: IDX_W];
  assign i1 = ld1_addr[`DC_INDEX_LSB +: IDX_W];
  assign si = st_addr[`DC_INDEX_LSB +: IDX_W];
  assign conflict = (b0 == b1) && (i0 != i1);

  // the younger load never goes alone, so order is kept
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ld_done_reg  <= 2'h0;
      ld0_data_reg <= '0;
      ld1_data_reg <= '0;
    end else if (ce) begin
      ld_done_reg[0] <= ld_valid[0];
      ld_done_reg[1] <= ld_valid[0] && ld_valid[1] && !conflict;
      ld0_data_reg   <= bank_mem[b0][i0];
      ld1_data_reg   <= bank_mem[b1][i1];
    end
  end

  // miss table
  logic [`DC_MISS_MAX-1:0] ent_valid, ent_hit, ent_alloc, ent_clear;
  dc_pkg::line_t           ent_line [`DC_MISS_MAX];
  dc_pkg::req_kind_t       ent_kind [`DC_MISS_MAX];
  miss_state_t             state;
  logic                    castout_done_reg;
  logic                    any_hit, any_free, st_block, take, need_castout;
  logic [`DC_MISS_ID_W-1:0] hit_id, free_id;

  for (genvar g = 0; g < `DC_MISS_MAX; g++) begin : g_ent
    assign ent_clear[g] = fill_in.valid && (fill_in.id == `DC_MISS_ID_W'(g));
    miss_entry u_ent (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .ce       (ce),
      .alloc    (ent_alloc[g]),
      .clear    (ent_clear[g]),
      .line_in  (miss_req.line),
      .kind_in  (miss_req.kind),
      .cmp_line (miss_req.line),
      .valid    (ent_valid[g]),
      .line     (ent_line[g]),
      .kind     (ent_kind[g]),
      .hit      (ent_hit[g])
    );
  end

  always_comb begin
    hit_id  = '0;
    free_id = '0;
    for (int k = `DC_MISS_MAX - 1; k >= 0; k--) begin
      if (ent_hit[k]) hit_id = k[`DC_MISS_ID_W-1:0];
      if (!ent_valid[k]) free_id = k[`DC_MISS_ID_W-1:0];
    end
  end
  assign any_hit  = |ent_hit;
  assign any_free = !(&ent_valid);
  assign st_block = stq_valid && (stq_line == miss_req.line) &&
                    (miss_req.kind == dc_pkg::REQ_PREFETCH ||
                     miss_req.kind == dc_pkg::REQ_PREFETCHW);
  assign need_castout = (miss_req.kind == dc_pkg::REQ_IFETCH) &&
                        miss_req.other_mod && !castout_done_reg;
  // one request at a time, in arrival order; a full table stalls it unless its line is already held
  assign take = miss_valid && !miss_ack_reg && (state == ST_IDLE) && !st_block &&
                !need_castout && (any_hit || any_free);
  assign ent_alloc = (take && !any_hit) ?
                     (`DC_MISS_MAX'(1) << free_id) : '0;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state            <= ST_IDLE;
      castout_done_reg <= 1'b0;
      wb_req_reg       <= 1'b0;
      wb_line_reg      <= '0;
    end else if (ce) begin
      case (state)
        ST_IDLE: begin
          if (miss_valid && !miss_ack_reg && need_castout) begin
            state       <= ST_CASTOUT;
            wb_req_reg  <= 1'b1;
            wb_line_reg <= miss_req.line;
          end
          if (take) castout_done_reg <= 1'b0;
        end
        ST_CASTOUT: begin
          if (wb_done) begin
            state            <= ST_IDLE;
            wb_req_reg       <= 1'b0;
            castout_done_reg <= 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      miss_ack_reg      <= 1'b0;
      miss_id_reg       <= '0;
      mreq_valid_reg    <= 1'b0;
      mreq_line_reg     <= '0;
      mreq_id_reg       <= '0;
      ic_inval_reg      <= 1'b0;
      ic_inval_line_reg <= '0;
    end else if (ce) begin
      miss_ack_reg   <= take;
      mreq_valid_reg <= take && !any_hit;
      ic_inval_reg   <= take && miss_req.other_hit &&
                        (miss_req.kind != dc_pkg::REQ_IFETCH);
      if (take) begin
        miss_id_reg       <= any_hit ? hit_id : free_id;
        mreq_line_reg     <= miss_req.line;
        mreq_id_reg       <= free_id;
        ic_inval_line_reg <= miss_req.line;
      end
    end
  end

  // fill: whole line into the data array unless bound for the icache
  logic       fill_ic;
  logic [2:0] fill_bank_hi;
  assign fill_ic      = ent_kind[fill_in.id] == dc_pkg::REQ_IFETCH;
  assign fill_bank_hi = {ent_line[fill_in.id][0], 2'h0};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fill_out_reg <= '0;
    end else if (ce) begin
      fill_out_reg.valid     <= fill_in.valid && ent_valid[fill_in.id];
      fill_out_reg.line      <= ent_line[fill_in.id];
      fill_out_reg.modified  <= ent_kind[fill_in.id] == dc_pkg::REQ_PREFETCHW;
      fill_out_reg.to_icache <= fill_ic;
    end
  end

  // array writes; a fill and a store to one bank in a cycle let the store land last
  always_ff @(posedge sys_clk) begin
    if (ce) begin
      if (fill_in.valid && !fill_ic) begin
        for (int c = 0; c < `DC_CHUNKS; c++) begin
          bank_mem[fill_bank_hi + 3'(c)][ent_line[fill_in.id][IDX_W-1:0]] <=
            fill_in.data[c*8*`DC_BANK_BYTES +: 8*`DC_BANK_BYTES];
        end
      end
      if (st_valid) bank_mem[sb][si] <= st_data;
    end
  end

  // write combining buffer, one line deep
  logic                        wc_open_reg;
  dc_pkg::line_t               wc_line_reg;
  logic [8*`DC_LINE_BYTES-1:0] wc_data_reg, wc_data_m;
  logic [`DC_LINE_BYTES-1:0]   wc_mask_reg, wc_mask_m;
  logic                        wc_same, wc_full, wc_flush;

  assign wc_same = wc_open_reg && (wc_line_reg == wc_wr.line);
  always_comb begin
    wc_data_m = wc_same ? wc_data_reg : '0;
    wc_mask_m = wc_same ? wc_mask_reg : '0;
    for (int b = 0; b < `DC_BANK_BYTES; b++) begin
      if (wc_wr.be[b]) begin
        wc_data_m[({wc_wr.chunk, 4'h0} + 6'(b))*8 +: 8] = wc_wr.data[b*8 +: 8];
        wc_mask_m[{wc_wr.chunk, 4'h0} + 6'(b)] = 1'b1;
      end
    end
  end
  assign wc_full  = &wc_mask_m;
  assign wc_flush = wc_open_reg && (fence || (wc_wr.valid && !wc_same));

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wc_open_reg  <= 1'b0;
      wc_line_reg  <= '0;
      wc_data_reg  <= '0;
      wc_mask_reg  <= '0;
      wc_flush_reg <= '0;
    end else if (ce) begin
      wc_flush_reg.valid <= 1'b0;
      if (wc_flush) begin
        wc_flush_reg <= {1'b1, wc_line_reg, wc_data_reg, wc_mask_reg};
        wc_open_reg  <= 1'b0;
      end
      if (wc_wr.valid && !(fence && wc_same)) begin
        if (wc_full) begin
          wc_flush_reg <= {1'b1, wc_wr.line, wc_data_m, wc_mask_m};
          wc_open_reg  <= 1'b0;
        end else begin
          wc_open_reg <= 1'b1;
          wc_line_reg <= wc_wr.line;
          wc_data_reg <= wc_data_m;
          wc_mask_reg <= wc_mask_m;
        end
      end
    end
  end

  a_conflict_single: assert property (@(posedge sys_clk) disable iff (rst)
    ce && ld_valid == 2'h3 && conflict |=> ld_done_reg == 2'h1)
    else $error("conflicting pair served twice");
  a_pair_dual: assert property (@(posedge sys_clk) disable iff (rst)
    ce && ld_valid == 2'h3 && b0 == b1 && i0 == i1 |=> ld_done_reg == 2'h3)
    else $error("same bank same index pair not dual");
  a_load_order: assert property (@(posedge sys_clk) disable iff (rst)
    ld_done_reg[1] |-> ld_done_reg[0])
    else $error("younger load served alone");
  a_table_limit: assert property (@(posedge sys_clk) disable iff (rst)
    ce && &ent_valid |=> !mreq_valid_reg)
    else $error("read issued with table full");
  a_merge_noread: assert property (@(posedge sys_clk) disable iff (rst)
    ce && take && any_hit |=> miss_ack_reg && !mreq_valid_reg)
    else $error("same line took a second entry");
  a_full_hold: assert property (@(posedge sys_clk) disable iff (rst)
    ce && miss_valid && &ent_valid && !any_hit |=> !miss_ack_reg)
    else $error("request taken with table full");
  a_store_block: assert property (@(posedge sys_clk) disable iff (rst)
    ce && st_block |=> !miss_ack_reg)
    else $error("prefetch passed matching store");
  a_pfw_modified: assert property (@(posedge sys_clk) disable iff (rst)
    ce && fill_in.valid && ent_valid[fill_in.id] &&
    ent_kind[fill_in.id] == dc_pkg::REQ_PREFETCHW |=> fill_out_reg.modified)
    else $error("write prefetch fill not modified");
  sequence s_castout;
    ce && state == ST_IDLE && miss_valid && !miss_ack_reg && need_castout ##1 wb_req_reg;
  endsequence
  a_castout_first: assert property (@(posedge sys_clk) disable iff (rst)
    s_castout |-> !miss_ack_reg ##1 !miss_ack_reg)
    else $error("ifetch taken before castout");
  a_ic_clean: assert property (@(posedge sys_clk) disable iff (rst)
    fill_out_reg.valid && fill_out_reg.to_icache |-> !fill_out_reg.modified)
    else $error("icache fill marked modified");
  a_wc_fence: assert property (@(posedge sys_clk) disable iff (rst)
    ce && fence && wc_open_reg |=> wc_flush_reg.valid && !wc_open_reg)
    else $error("fence left combiner open");
endmodule

//--- sim/mem_side_model.sv
// memory side stand-in: returns requested lines and acks castouts
// assumes dc_pkg is compiled first; hold stalls all fills
`timescale 1ns/100ps
`include "dc_map.svh"
module mem_side_model (
  input  wire logic                     sys_clk,    // core clock
  input  wire logic                     rst,        // async reset
  input  wire logic                     hold,       // stall fills
  input  wire logic                     mreq_valid, // line read
  input  wire logic [`DC_MISS_ID_W-1:0] mreq_id,    // its tag
  input  wire logic                     wb_req,     // castout level
  output dc_pkg::fill_in_t              fill_in,    // line back
  output logic                          wb_done     // castout written
);
  logic [`DC_MISS_ID_W-1:0] pend[$];
  int                       wb_cnt;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pend.delete();
      wb_cnt = 0;
      fill_in <= '0;
      wb_done <= 1'b0;
    end else begin
      if (mreq_valid) pend.push_back(mreq_id);
      fill_in.valid <= 1'b0;
      fill_in.data <= ~fill_in.data;  // no stale line between fills
      if (!hold && pend.size() > 0) begin
        fill_in.valid <= 1'b1;
        fill_in.id <= pend.pop_front();
        fill_in.data <= {16{32'hC0DE5A5A}};
      end
      wb_done <= 1'b0;
      wb_cnt = (wb_req && !wb_done) ? wb_cnt + 1 : 0;
      if (wb_cnt == 3) wb_done <= 1'b1;
    end
  end
endmodule

//--- sim/l1_dcache_bank_and_miss_logic_tb.sv
// self-checking bench for the data cache bank and miss logic
// assumes mem_side_model answers the lower memory side
`timescale 1ns/100ps
`include "dc_map.svh"
module l1_dcache_bank_and_miss_logic_tb;
  logic sys_clk, rst, ce, st_valid, stq_valid, miss_valid, fence, hold;
  logic [1:0] ld_valid, ld_done_reg;
  logic [31:0] ld0_addr, ld1_addr, st_addr;
  logic [127:0] ld0_data_reg, ld1_data_reg, st_data;
  logic miss_ack_reg, mreq_valid_reg, wb_req_reg, wb_done, ic_inval_reg;
  logic [2:0] miss_id_reg, mreq_id_reg;
  dc_pkg::line_t stq_line, mreq_line_reg, wb_line_reg, ic_inval_line_reg, wb_seen, inv_seen;
  dc_pkg::miss_req_t miss_req;
  dc_pkg::fill_in_t fill_in;
  dc_pkg::fill_out_t fill_out_reg;
  dc_pkg::wc_write_t wc_wr;
  dc_pkg::wc_flush_t wc_flush_reg;
  int bad_count, tests_run;
  logic got, mq, inv;
  logic [2:0] id;
  l1_dcache_bank_and_miss_logic #(.IDX_W(4)) l1_dcache_bank_and_miss_logic_inst (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .ld_valid(ld_valid), .ld0_addr(ld0_addr),
    .ld1_addr(ld1_addr), .ld_done_reg(ld_done_reg), .ld0_data_reg(ld0_data_reg),
    .ld1_data_reg(ld1_data_reg), .st_valid(st_valid), .st_addr(st_addr), .st_data(st_data),
    .stq_valid(stq_valid), .stq_line(stq_line), .miss_valid(miss_valid), .miss_req(miss_req),
    .miss_ack_reg(miss_ack_reg), .miss_id_reg(miss_id_reg), .mreq_valid_reg(mreq_valid_reg),
    .mreq_line_reg(mreq_line_reg), .mreq_id_reg(mreq_id_reg), .fill_in(fill_in),
    .fill_out_reg(fill_out_reg), .wb_req_reg(wb_req_reg), .wb_line_reg(wb_line_reg),
    .wb_done(wb_done), .ic_inval_reg(ic_inval_reg), .ic_inval_line_reg(ic_inval_line_reg),
    .wc_wr(wc_wr), .fence(fence), .wc_flush_reg(wc_flush_reg));
  mem_side_model mem_side_model_inst (
    .sys_clk(sys_clk), .rst(rst), .hold(hold), .mreq_valid(mreq_valid_reg),
    .mreq_id(mreq_id_reg), .wb_req(wb_req_reg), .fill_in(fill_in), .wb_done(wb_done));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (wb_req_reg === 1'b1) wb_seen <= wb_line_reg;
    if (ic_inval_reg === 1'b1) inv_seen <= ic_inval_line_reg;
  end
  task automatic check(input string nm, input logic [511:0] seen, input logic [511:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic step();
    @(posedge sys_clk);
    #2;
  endtask
  function automatic logic [127:0] wd(input int i);
    return {4{32'hA5A50000 + i}};
  endfunction
  task automatic ldp(input logic [31:0] a0, a1, input logic [1:0] v, ed, input int e0, e1);
    ld_valid = v;
    ld0_addr = a0;
    ld1_addr = a1;
    step();
    ld_valid = 2'b00;
    check("ld_done", ld_done_reg, ed);
    if (ed[0]) check("ld0_data", ld0_data_reg, wd(e0));
    if (ed[1]) check("ld1_data", ld1_data_reg, wd(e1));
    step();
  endtask
  task automatic miss(input dc_pkg::req_kind_t k, input dc_pkg::line_t ln,
                      input logic oh, om, input int n);
    miss_valid = 1'b1;
    miss_req = '{k, ln, oh, om};
    got = 1'b0;
    for (int i = 0; i < n && !got; i++) begin
      step();
      if (miss_ack_reg === 1'b1) begin
        got = 1'b1;
        id = miss_id_reg;
        mq = mreq_valid_reg;
        inv = ic_inval_reg;
        if (mq === 1'b1) check("mreq_line", mreq_line_reg, ln);
        if (mq === 1'b1) check("mreq_id", mreq_id_reg, id);
      end
    end
    miss_valid = 1'b0;
    step();
  endtask
  task automatic wait_fill(input dc_pkg::line_t ln, input logic em, input logic ei);
    logic f;
    f = 1'b0;
    for (int i = 0; i < 40 && !f; i++) begin
      step();
      if (fill_out_reg.valid === 1'b1 && fill_out_reg.line === ln) begin
        f = 1'b1;
        check("fill_mod", fill_out_reg.modified, em);
        check("fill_ic", fill_out_reg.to_icache, ei);
      end
    end
    check("fill_seen", f, 1'b1);
  endtask
  task automatic wc_put(input dc_pkg::line_t ln, input logic [1:0] ch, input logic [15:0] be,
                        input logic ev, input dc_pkg::line_t el, input logic [63:0] em);
    wc_wr = '{1'b1, ln, ch, wd(ch), be};
    fence = (be == 16'h0000);
    if (fence) wc_wr = '0;
    step();
    wc_wr = '0;
    fence = 1'b0;
    check("wc_valid", wc_flush_reg.valid, ev);
    if (ev) check("wc_line", wc_flush_reg.line, el);
    if (ev) check("wc_mask", wc_flush_reg.mask, em);
    step();
  endtask
  logic [31:0] st_addr_tab[4] = '{32'h000, 32'h010, 32'h080, 32'h040};
  task automatic t_loads();
    st_valid = 1'b1;
    foreach (st_addr_tab[i]) begin
      st_addr = st_addr_tab[i];
      st_data = wd(i);
      step();
    end
    st_valid = 1'b0;
    step();
    ldp(32'h000, 32'h010, 2'b11, 2'b11, 0, 1);
    ldp(32'h000, 32'h008, 2'b11, 2'b11, 0, 0);
    ldp(32'h000, 32'h080, 2'b11, 2'b01, 0, 0);
    ldp(32'h080, 32'h040, 2'b11, 2'b11, 2, 3);
    ldp(32'h000, 32'h000, 2'b10, 2'b00, 0, 0);
    // ce low must freeze the served flags
    ce = 1'b0;
    ldp(32'h000, 32'h010, 2'b11, 2'b00, 0, 0);
    ce = 1'b1;
  endtask
  task automatic t_table();
    hold = 1'b1;
    for (int i = 0; i < 8; i++) begin
      miss(dc_pkg::REQ_LOAD, 26'(26'h100 + i), 1'b0, 1'b0, 5);
      check("ack", got, 1'b1);
      check("id", id, i);
    end
    miss(dc_pkg::REQ_LOAD, 26'h103, 1'b0, 1'b0, 5);
    check("reuse_id", id, 3'd3);
    check("reuse_mreq", mq, 1'b0);
    miss(dc_pkg::REQ_LOAD, 26'h1F0, 1'b0, 1'b0, 8);
    check("full_ack", got, 1'b0);
    fork
      miss(dc_pkg::REQ_LOAD, 26'h1F0, 1'b0, 1'b0, 20);
      begin
        repeat (3) step();
        hold = 1'b0;
      end
    join
    check("late_ack", got, 1'b1);
    check("late_id", id, 3'd0);
    repeat (20) step();
  endtask
  task automatic t_coherent();
    stq_valid = 1'b1;
    stq_line = 26'h200;
    miss(dc_pkg::REQ_PREFETCH, 26'h200, 1'b0, 1'b0, 8);
    check("pf_block", got, 1'b0);
    stq_valid = 1'b0;
    miss(dc_pkg::REQ_PREFETCH, 26'h200, 1'b0, 1'b0, 8);
    check("pf_go", got, 1'b1);
    wait_fill(26'h200, 1'b0, 1'b0);
    miss(dc_pkg::REQ_PREFETCHW, 26'h201, 1'b0, 1'b0, 8);
    wait_fill(26'h201, 1'b1, 1'b0);
    miss(dc_pkg::REQ_IFETCH, 26'h300, 1'b1, 1'b1, 30);
    check("if_ack", got, 1'b1);
    check("wb_line", wb_seen, 26'h300);
    wait_fill(26'h300, 1'b0, 1'b1);
    miss(dc_pkg::REQ_LOAD, 26'h301, 1'b1, 1'b0, 8);
    check("inv", inv, 1'b1);
    check("inv_line", inv_seen, 26'h301);
    repeat (5) step();
  endtask
  task automatic t_combine();
    wc_put(26'hA, 2'd0, 16'hFFFF, 1'b0, 26'h0, 64'h0);
    wc_put(26'hA, 2'd2, 16'h00FF, 1'b0, 26'h0, 64'h0);
    wc_wr = '{1'b1, 26'hB, 2'd1, wd(1), 16'hFFFF};
    step();
    wc_wr = '0;
    check("wc_data", wc_flush_reg.data[127:0], wd(0));
    check("wc_line", wc_flush_reg.line, 26'hA);
    check("wc_mask", wc_flush_reg.mask, 64'h000000FF0000FFFF);
    step();
    wc_put(26'h0, 2'd0, 16'h0000, 1'b1, 26'hB, 64'h00000000FFFF0000);
    for (int c = 0; c < 4; c++)
      wc_put(26'hC, c, 16'hFFFF, c == 3, 26'hC, 64'hFFFFFFFFFFFFFFFF);
  endtask
  initial begin
    bad_count = 0;
    tests_run = 0;
    rst = 1'b1;
    ce = 1'b1;
    {ld_valid, st_valid, stq_valid, miss_valid, fence, hold} = '0;
    {ld0_addr, ld1_addr, st_addr, st_data, stq_line} = '0;
    miss_req = '0;
    wc_wr = '0;
    repeat (16) @(posedge sys_clk);
    #2;
    rst = 1'b0;
    check("rst_out", {ld_done_reg, miss_ack_reg, wb_req_reg, wc_flush_reg.valid}, 5'h0);
    t_loads();
    t_table();
    t_coherent();
    t_combine();
    final_report();
  end
  initial begin
    #500000;
    bad_count++;
    final_report();
  end
endmodule
